// file: pkg/smp_consts.svh
// Purpose: offsets, field positions, reset values for the modem/printer signal block
// Assumes: three-bit register select, eight-bit data
// Notes:   included by bare name
`ifndef SMP_CONSTS_SVH
`define SMP_CONSTS_SVH

// ****************************************
// register select codes
// ****************************************
`define SMP_SER_MCR      3'h4
`define SMP_SER_MSR      3'h6
`define SMP_PRN_DATA     3'h0
`define SMP_PRN_STAT     3'h1
`define SMP_PRN_CTRL     3'h2

// ****************************************
// modem control fields
// ****************************************
`define SMP_MCR_DTR      0
`define SMP_MCR_RTS      1
`define SMP_MCR_IRQ_OE   3
`define SMP_MCR_LOOP     4
`define SMP_MCR_RST      5'h00

// ****************************************
// modem status fields
// ****************************************
`define SMP_MSR_CTS_D    0
`define SMP_MSR_DSR_D    1
`define SMP_MSR_RI_TE    2
`define SMP_MSR_DCD_D    3

// ****************************************
// printer control and status fields
// ****************************************
`define SMP_PCTL_INIT    2
`define SMP_PCTL_IRQ_EN  4
`define SMP_PCTL_RST     5'h00
`define SMP_PSTAT_IRQ    2
`define SMP_PSTAT_ERR_N  3
`define SMP_PSTAT_PAPER  5
`define SMP_PSTAT_ACK_N  6

// ****************************************
// pin synchroniser reset image and data byte reset value (idle levels)
// ****************************************
`define SMP_PIN_RST      23'h7EF800
`define SMP_BYTE_RST     8'h00

`endif

// file: pkg/smp_pkg.sv
// Purpose: types shared by the modem/printer signal block
// Assumes: smp_consts.svh holds the numbers
// Notes:   field order of smp_pins_t matches SMP_PIN_RST
`default_nettype none
package smp_pkg;

   // ****************************************
   // pin inputs from outside the clock domain
   // ****************************************
   typedef struct packed {
      logic       cts_n;
      logic       dsr_n;
      logic       ring_n;
      logic       carrier_detect_n;
      logic       ack_n;
      logic       error_n;
      logic       paper_out;
      logic       parallel_out_enable_n;
      logic       cs_serial_n;
      logic       cs_printer_n;
      logic       read_strobe_n;
      logic       write_strobe_n;
      logic [2:0] addr;
      logic [7:0] db;
   } smp_pins_t;

   typedef struct packed {
      logic o;
      logic oe;
   } smp_tri_t;

   typedef struct packed {
      logic prev;
      logic flag;
   } smp_delta_st_t;

   typedef struct packed {
      logic [4:0] modem_control_reg;
      logic [4:0] pctl;
      logic [7:0] wdata;
      logic [7:0] rdata;
      logic       rd_prev;
      logic       wr_prev;
      logic       ack_prev;
      logic       prn_irq;
      logic       db_oe;
      logic       dtr_n;
      logic       rts_n;
      smp_tri_t   ser_irq;
      smp_tri_t   prn_irq_out;
      smp_tri_t   init;
      logic       pd_oe;
   } smp_top_st_t;

endpackage
`default_nettype wire

// file: design/smp_sync.sv
// Purpose: two-stage synchroniser for a bundle of pin inputs
// Assumes: single clock ref_clk
// Notes:   first stage feeds only the second
`default_nettype none
module smp_sync #(
   parameter int          WIDTH = 1,
   parameter logic [WIDTH-1:0] RST = '0
) (
   input  wire logic             ref_clk,
   input  wire logic             arst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q   <= RST;
         sync_out <= RST;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule
`default_nettype wire

// file: design/smp_delta.sv
// Purpose: sticky change flag for one modem status input
// Assumes: sample already synchronised
// Notes:   set wins over a clear in the same cycle
`default_nettype none
module smp_delta
   import smp_pkg::*;
#(
   parameter bit RISE_ONLY = 1'b0
) (
   input  wire logic ref_clk,
   input  wire logic arst_n,
   input  wire logic sample,
   input  wire logic clr,
   output var  logic flag
);

   smp_delta_st_t st_q;
   smp_delta_st_t st_d;
   logic          hit;

   always_comb begin
      hit = RISE_ONLY ? (~st_q.prev & sample) : (st_q.prev ^ sample);
      st_d      = st_q;
      st_d.prev = sample;
      st_d.flag = hit | (st_q.flag & ~clr);
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= '{prev: 1'b1, flag: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   assign flag = st_q.flag;

endmodule
`default_nettype wire

// file: design/smp_top.sv
// Purpose: modem control/status, serial and printer interrupts, printer port pins
// Assumes: host strobes and modem/printer lines are asynchronous pins
// Notes:   framing, baud and receive/transmit paths live elsewhere
//
// Overview of operation
// - setting control bit 0 drives terminal-ready low
// - terminal-ready inactive on reset, in loop mode, or bit 0 clear
// - setting the send-request bit drives request-to-send low
// - request-to-send high on reset, in loop mode, or bit 1 clear
// - serial interrupt is active high, driven only while control bit 3 set
// - serial interrupt from receive error, data ready, transmit empty, modem change
// - serial interrupt falls when serviced or on reset
// - printer interrupt active high, raised by acknowledge rising edge
// - printer interrupt driven only while printer control bit 4 set
// - read strobe low with chip select returns addressed register
// - write strobe low with chip select stores into addressed register
// - output-enable low drives write data onto parallel lines
// - output-enable high floats all eight parallel lines
// - printer-initialise is open drain, pulled low to start initialisation
// - reset clears registers and sets outputs to idle states
// - ring input state shown in status bit 6
// - ring low-to-high since last read sets status bit 2
// - ring trailing edge raises serial interrupt when modem interrupt enabled
// - carrier-detect input state shown in status bit 7
// - carrier-detect change sets status bit 3, may interrupt
// - clear-to-send in bit 4, its change flag in bit 0
// - set-ready in bit 5, its change flag in bit 1
`default_nettype none
`include "smp_consts.svh"
module smp_top
   import smp_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       arst_n,
   input  wire logic       cts_n,
   input  wire logic       dsr_n,
   input  wire logic       ring_n,
   input  wire logic       carrier_detect_in_n,
   input  wire logic       ack_n,
   input  wire logic       error_n,
   input  wire logic       paper_out_in,
   input  wire logic       parallel_out_enable_n,
   input  wire logic       cs_serial_n,
   input  wire logic       cs_printer_n,
   input  wire logic       read_strobe_n,
   input  wire logic       write_strobe_n,
   input  wire logic [2:0] addr,
   input  wire logic [7:0] db_i,
   input  wire logic       rx_error,
   input  wire logic       rx_data_avail,
   input  wire logic       thr_empty,
   input  wire logic       modem_irq_en,
   output var  logic [7:0] db_o,
   output var  logic       db_oe,
   output var  logic       dtr_n,
   output var  logic       rts_n,
   output var  logic       serial_irq_out,
   output var  logic       serial_irq_oe,
   output var  logic       printer_irq_out,
   output var  logic       printer_irq_oe,
   output var  logic [7:0] parallel_data_lines_o,
   output var  logic       parallel_data_lines_oe,
   output var  logic       init_o,
   output var  logic       init_oe
);

   // ****************************************
   // pin synchronisers
   // ****************************************
   smp_pins_t pins_raw;
   smp_pins_t pins_s;

   always_comb begin
      pins_raw = '{cts_n: cts_n, dsr_n: dsr_n, ring_n: ring_n,
                   carrier_detect_n: carrier_detect_in_n, ack_n: ack_n,
                   error_n: error_n, paper_out: paper_out_in,
                   parallel_out_enable_n: parallel_out_enable_n,
                   cs_serial_n: cs_serial_n, cs_printer_n: cs_printer_n,
                   read_strobe_n: read_strobe_n, write_strobe_n: write_strobe_n,
                   addr: addr, db: db_i};
   end

   smp_sync #(
      .WIDTH    ($bits(smp_pins_t)),
      .RST      (`SMP_PIN_RST)
   ) u_sync (
      .ref_clk  (ref_clk),
      .arst_n   (arst_n),
      .async_in (pins_raw),
      .sync_out (pins_s)
   );

   // ****************************************
   // modem status change flags
   // ****************************************
   logic       msr_clr;
   logic [3:0] delta;

   smp_delta #(.RISE_ONLY(1'b0)) u_clear_to_send_delta (
      .ref_clk (ref_clk), .arst_n (arst_n), .sample (pins_s.cts_n),
      .clr (msr_clr), .flag (delta[`SMP_MSR_CTS_D]));
   smp_delta #(.RISE_ONLY(1'b0)) u_set_ready_delta (
      .ref_clk (ref_clk), .arst_n (arst_n), .sample (pins_s.dsr_n),
      .clr (msr_clr), .flag (delta[`SMP_MSR_DSR_D]));
   // ring counts only its trailing edge, low to high
   smp_delta #(.RISE_ONLY(1'b1)) u_ring_trailing_edge_flag (
      .ref_clk (ref_clk), .arst_n (arst_n), .sample (pins_s.ring_n),
      .clr (msr_clr), .flag (delta[`SMP_MSR_RI_TE]));
   smp_delta #(.RISE_ONLY(1'b0)) u_carrier_detect_delta (
      .ref_clk (ref_clk), .arst_n (arst_n), .sample (pins_s.carrier_detect_n),
      .clr (msr_clr), .flag (delta[`SMP_MSR_DCD_D]));

   // ****************************************
   // next state
   // ****************************************
   smp_top_st_t st_q;
   smp_top_st_t st_d;
   logic        ser_sel;
   logic        prn_sel;
   logic        rd_act;
   logic        wr_act;
   logic        rd_go;
   logic        wr_go;
   logic        ack_rise;
   logic        loop_on;
   logic [7:0]  msr_val;
   logic [7:0]  pstat_val;
   logic        ser_cause;

   always_comb begin
      ser_sel  = ~pins_s.cs_serial_n;
      prn_sel  = ~pins_s.cs_printer_n;
      rd_act   = ~pins_s.read_strobe_n & (ser_sel | prn_sel);
      wr_act   = ~pins_s.write_strobe_n & (ser_sel | prn_sel);
      rd_go    = rd_act & ~st_q.rd_prev;
      wr_go    = wr_act & ~st_q.wr_prev;
      ack_rise = pins_s.ack_n & ~st_q.ack_prev;
      loop_on  = st_q.modem_control_reg[`SMP_MCR_LOOP];
      // line state bits 7:4 read as one while the modem line is asserted (low)
      msr_val  = {~pins_s.carrier_detect_n, ~pins_s.ring_n,
                  ~pins_s.dsr_n, ~pins_s.cts_n, delta};
      pstat_val = 8'h00;
      pstat_val[`SMP_PSTAT_IRQ]   = st_q.prn_irq;
      pstat_val[`SMP_PSTAT_ERR_N] = pins_s.error_n;
      pstat_val[`SMP_PSTAT_PAPER] = pins_s.paper_out;
      pstat_val[`SMP_PSTAT_ACK_N] = pins_s.ack_n;
      // the cause is a level, so servicing the source drops it
      ser_cause = rx_error | rx_data_avail | thr_empty
                | (modem_irq_en & (|delta));
      msr_clr  = rd_go & ser_sel & (pins_s.addr == `SMP_SER_MSR);

      st_d          = st_q;
      st_d.rd_prev  = rd_act;
      st_d.wr_prev  = wr_act;
      st_d.ack_prev = pins_s.ack_n;
      st_d.db_oe    = rd_act;

      if (rd_go) begin
         st_d.rdata = 8'h00;
         if (ser_sel) begin
            unique case (pins_s.addr)
               `SMP_SER_MCR: st_d.rdata = {3'h0, st_q.modem_control_reg};
               `SMP_SER_MSR: st_d.rdata = msr_val;
               default:      st_d.rdata = 8'h00;
            endcase
         end else begin
            unique case (pins_s.addr)
               `SMP_PRN_DATA: st_d.rdata = st_q.wdata;
               `SMP_PRN_STAT: st_d.rdata = pstat_val;
               `SMP_PRN_CTRL: st_d.rdata = {3'h0, st_q.pctl};
               default:       st_d.rdata = 8'h00;
            endcase
         end
      end

      if (wr_go) begin
         if (ser_sel && pins_s.addr == `SMP_SER_MCR) begin
            st_d.modem_control_reg = pins_s.db[4:0];
         end else if (prn_sel && pins_s.addr == `SMP_PRN_DATA) begin
            st_d.wdata = pins_s.db;
         end else if (prn_sel && pins_s.addr == `SMP_PRN_CTRL) begin
            st_d.pctl = pins_s.db[4:0];
         end
      end

      // acknowledge edge wins over the clear by a status read
      st_d.prn_irq = ack_rise
                   | (st_q.prn_irq & ~(rd_go & prn_sel & (pins_s.addr == `SMP_PRN_STAT)));

      st_d.dtr_n = ~(st_q.modem_control_reg[`SMP_MCR_DTR] & ~loop_on);
      st_d.rts_n = ~(st_q.modem_control_reg[`SMP_MCR_RTS] & ~loop_on);
      st_d.ser_irq.o  = ser_cause;
      st_d.ser_irq.oe = st_q.modem_control_reg[`SMP_MCR_IRQ_OE];
      st_d.prn_irq_out.o  = st_q.prn_irq;
      st_d.prn_irq_out.oe = st_q.pctl[`SMP_PCTL_IRQ_EN];
      // open drain: only ever pulls low, pullup is on the pad
      st_d.init.o  = 1'b0;
      st_d.init.oe = st_q.pctl[`SMP_PCTL_INIT];
      st_d.pd_oe   = ~pins_s.parallel_out_enable_n;
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q       <= '0;
         st_q.modem_control_reg   <= `SMP_MCR_RST;
         st_q.pctl  <= `SMP_PCTL_RST;
         st_q.wdata <= `SMP_BYTE_RST;
         st_q.rdata <= `SMP_BYTE_RST;
         st_q.rd_prev  <= 1'b0;
         st_q.wr_prev  <= 1'b0;
         st_q.ack_prev <= 1'b1;
         st_q.dtr_n <= 1'b1;
         st_q.rts_n <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // ****************************************
   // outputs, all from flip-flops
   // ****************************************
   assign db_o                   = st_q.rdata;
   assign db_oe                  = st_q.db_oe;
   assign dtr_n                  = st_q.dtr_n;
   assign rts_n                  = st_q.rts_n;
   assign serial_irq_out         = st_q.ser_irq.o;
   assign serial_irq_oe          = st_q.ser_irq.oe;
   assign printer_irq_out        = st_q.prn_irq_out.o;
   assign printer_irq_oe         = st_q.prn_irq_out.oe;
   assign parallel_data_lines_o  = st_q.wdata;
   assign parallel_data_lines_oe = st_q.pd_oe;
   assign init_o                 = st_q.init.o;
   assign init_oe                = st_q.init.oe;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   chk_dtr_follows_mcr:
   assert property (st_q.modem_control_reg[`SMP_MCR_DTR] && !loop_on |=> !dtr_n)
      else $error("terminal-ready not asserted");
   chk_dtr_inactive:
   assert property (!st_q.modem_control_reg[`SMP_MCR_DTR] || loop_on |=> dtr_n)
      else $error("terminal-ready not released");
   chk_rts_follows_mcr:
   assert property (st_q.modem_control_reg[`SMP_MCR_RTS] && !loop_on |=> !rts_n)
      else $error("request-to-send not asserted");
   chk_rts_inactive:
   assert property (!st_q.modem_control_reg[`SMP_MCR_RTS] || loop_on |=> rts_n)
      else $error("request-to-send not released");
   chk_ser_irq_enable:
   assert property (serial_irq_oe == $past(st_q.modem_control_reg[`SMP_MCR_IRQ_OE]))
      else $error("serial interrupt enable wrong");
   chk_ser_irq_cause:
   assert property (rx_data_avail |=> serial_irq_out)
      else $error("data ready did not interrupt");
   chk_ser_irq_drop:
   assert property (!rx_error && !rx_data_avail && !thr_empty && !modem_irq_en
                    |=> !serial_irq_out)
      else $error("serial interrupt stuck high");
   chk_prn_irq_edge:
   assert property (ack_rise |=> ##1 printer_irq_out)
      else $error("acknowledge edge did not interrupt");
   chk_prn_irq_oe:
   assert property (printer_irq_oe == $past(st_q.pctl[`SMP_PCTL_IRQ_EN]))
      else $error("printer interrupt enable wrong");
   chk_pd_drive:
   assert property (!pins_s.parallel_out_enable_n |=> parallel_data_lines_oe)
      else $error("parallel lines not driven");
   chk_pd_float:
   assert property (pins_s.parallel_out_enable_n |=> !parallel_data_lines_oe)
      else $error("parallel lines not released");
   chk_ring_state:
   assert property (rd_go && ser_sel && pins_s.addr == `SMP_SER_MSR
                    |=> db_o[6] == $past(~pins_s.ring_n))
      else $error("ring state misreported");
   chk_msr_clear:
   assert property (msr_clr && !(pins_s.ring_n && !$past(pins_s.ring_n))
                    ##1 $stable(pins_s.ring_n) |=> !delta[`SMP_MSR_RI_TE])
      else $error("ring flag not cleared by read");
   chk_ring_irq:
   assert property (modem_irq_en && delta[`SMP_MSR_RI_TE] |=> serial_irq_out)
      else $error("ring edge did not interrupt");

   cov_msr_read:  cover property (msr_clr && |delta);
   cov_mcr_write: cover property (wr_go && ser_sel && pins_s.addr == `SMP_SER_MCR);
   cov_prn_irq:   cover property (printer_irq_out && printer_irq_oe);
   cov_loop:      cover property (loop_on && st_q.modem_control_reg[`SMP_MCR_DTR]);

endmodule
`default_nettype wire

// file: tb/smp_far_model.sv
// Purpose: far-side modem and printer for the signal block bench
// Assumes: bench sets line levels at falling edges of ref_clk
// Notes:   floated parallel lines show a pattern that changes every cycle
`default_nettype none
module smp_far_model (
   input  wire logic       ref_clk,
   input  wire logic [3:0] modem_lvl,
   input  wire logic       ack_lvl,
   input  wire logic       fault,
   input  wire logic       no_paper,
   input  wire logic [7:0] pd_o,
   input  wire logic       pd_oe,
   input  wire logic       init_o,
   input  wire logic       init_oe,
   output var  logic       cts_n,
   output var  logic       dsr_n,
   output var  logic       ring_n,
   output var  logic       cd_n,
   output var  logic       ack_n,
   output var  logic       error_n,
   output var  logic       paper_out,
   output var  logic [7:0] pd_wire,
   output var  logic       init_wire
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] pd_last = 8'h00;

   // ****************************************
   // line levels
   // ****************************************
   always @(posedge ref_clk) pd_last <= pd_wire;

   always_comb begin
      {cd_n, ring_n, dsr_n, cts_n} = modem_lvl;
      ack_n = ack_lvl;
      error_n = !fault;
      paper_out = no_paper;
      // no pull on the data lines: inverse of last value, never a stale copy
      pd_wire = pd_oe ? pd_o : ~pd_last;
      init_wire = init_oe ? init_o : 1'b1;
   end
endmodule
`default_nettype wire

// file: tb/tb.sv
// Purpose: self-checking bench for the modem/printer signal block
// Assumes: strobes seen three edges after the pin moves
// Notes:   all inputs move at falling edges
`default_nettype none
`include "smp_consts.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic ref_clk = 1'b0, arst_n = 1'b0, pout_en_n = 1'b1, cs_ser_n = 1'b1, cs_prn_n = 1'b1;
   logic rd_n = 1'b1, wr_n = 1'b1, modem_irq_en = 1'b0;
   logic ack_lvl = 1'b1, fault = 1'b0, no_paper = 1'b0;
   logic [3:0] modem_lvl = 4'hF;
   logic [2:0] causes = 3'h0, addr = 3'h0;
   logic [7:0] db_i = 8'h00, db_o, pd_o, pd_wire;
   logic db_oe, dtr_n, rts_n, sirq, sirq_oe, pirq, pirq_oe, pd_oe, init_o, init_oe, init_wire;
   logic cts_n, dsr_n, ring_n, cd_n, ack_n, error_n, paper_out;
   int err_count = 0, comparisons = 0;

   always #5 ref_clk = ~ref_clk;

   smp_far_model far (.ref_clk(ref_clk), .modem_lvl(modem_lvl), .ack_lvl(ack_lvl),
      .fault(fault), .no_paper(no_paper), .pd_o(pd_o), .pd_oe(pd_oe), .init_o(init_o),
      .init_oe(init_oe), .cts_n(cts_n), .dsr_n(dsr_n), .ring_n(ring_n), .cd_n(cd_n),
      .ack_n(ack_n), .error_n(error_n), .paper_out(paper_out), .pd_wire(pd_wire),
      .init_wire(init_wire));

   smp_top DUT (.ref_clk(ref_clk), .arst_n(arst_n), .cts_n(cts_n), .dsr_n(dsr_n),
      .ring_n(ring_n), .carrier_detect_in_n(cd_n), .ack_n(ack_n), .error_n(error_n),
      .paper_out_in(paper_out), .parallel_out_enable_n(pout_en_n), .cs_serial_n(cs_ser_n),
      .cs_printer_n(cs_prn_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n), .addr(addr),
      .db_i(db_i), .rx_error(causes[2]), .rx_data_avail(causes[1]), .thr_empty(causes[0]),
      .modem_irq_en(modem_irq_en), .db_o(db_o), .db_oe(db_oe), .dtr_n(dtr_n),
      .rts_n(rts_n), .serial_irq_out(sirq), .serial_irq_oe(sirq_oe),
      .printer_irq_out(pirq), .printer_irq_oe(pirq_oe), .parallel_data_lines_o(pd_o),
      .parallel_data_lines_oe(pd_oe), .init_o(init_o), .init_oe(init_oe));

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   // one strobe per access; write held long enough to pass the synchronisers
   task automatic acc(input logic prn, input logic wr, input logic [2:0] a,
                      input logic [7:0] d, output logic [7:0] q);
      int n = 0;
      @(negedge ref_clk);
      addr = a;
      db_i = d;
      cs_ser_n = prn;
      cs_prn_n = !prn;
      if (wr) wr_n = 1'b0;
      else rd_n = 1'b0;
      if (wr) idle(5);
      else begin
         while (db_oe !== 1'b1 && n < 10) begin
            @(negedge ref_clk);
            n++;
         end
         if (db_oe !== 1'b1) begin
            chk("read handshake", {7'h00, db_oe}, 8'h01);
            results();
         end
      end
      q = db_o;
      {wr_n, rd_n, cs_ser_n, cs_prn_n} = 4'hF;
      idle(5);
   endtask

   task automatic wr(input logic prn, input logic [2:0] a, input logic [7:0] d);
      logic [7:0] q;
      acc(prn, 1'b1, a, d, q);
   endtask

   function automatic logic [7:0] outs();
      return {dtr_n, rts_n, sirq, sirq_oe, pirq, pirq_oe, init_oe, pd_oe};
   endfunction

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_modem_ctrl();
      logic [7:0] mc [4] = '{8'h01, 8'h02, 8'h13, 8'h0B};
      logic [7:0] ex [4] = '{8'h02, 8'h04, 8'h06, 8'h01};
      logic [7:0] q;
      for (int i = 0; i < 4; i++) begin
         wr(1'b0, `SMP_SER_MCR, mc[i]);
         chk("dtr rts irq_oe", {5'h00, dtr_n, rts_n, sirq_oe}, ex[i]);
      end
      acc(1'b0, 1'b0, `SMP_SER_MCR, 8'h00, q);
      chk("modem control read back", q, 8'h0B);
      // second reset in mid-run with outputs active
      arst_n = 1'b0;
      idle(2);
      chk("outputs in reset", outs(), 8'hC0);
      arst_n = 1'b1;
      idle(6);
      chk("outputs after reset", outs(), 8'hC0);
      acc(1'b0, 1'b0, `SMP_SER_MCR, 8'h00, q);
      chk("modem control after reset", q, 8'h00);
      $display("test modem control done");
   endtask

   task automatic t_irq_causes();
      logic [7:0] q;
      wr(1'b0, `SMP_SER_MCR, 8'h08);
      for (int i = 0; i < 3; i++) begin
         causes = 3'h1 << i;
         idle(3);
         chk("serial irq raised", {6'h00, sirq, sirq_oe}, 8'h03);
         causes = 3'h0;
         idle(3);
         chk("serial irq serviced", {7'h00, sirq}, 8'h00);
      end
      // modem change with the modem cause disabled must not interrupt
      modem_irq_en = 1'b0;
      modem_lvl = 4'hE;
      idle(5);
      chk("masked modem change", {7'h00, sirq}, 8'h00);
      acc(1'b0, 1'b0, `SMP_SER_MSR, 8'h00, q);
      chk("masked modem status", q, 8'h11);
      modem_lvl = 4'hF;
      idle(5);
      acc(1'b0, 1'b0, `SMP_SER_MSR, 8'h00, q);
      chk("masked modem status release", q, 8'h01);
      $display("test serial irq causes done");
   endtask

   task automatic t_modem_status();
      logic [7:0] q, e;
      logic [3:0] lvl = 4'hF;
      modem_irq_en = 1'b1;
      for (int i = 0; i < 4; i++) begin
         for (int s = 0; s < 2; s++) begin
            lvl[i] = s[0];
            modem_lvl = lvl;
            idle(5);
            e = {~lvl, 4'h0};
            // ring flags only its low-to-high edge
            e[i] = (i != 2 || s == 1);
            chk("modem change irq", {7'h00, sirq}, {7'h00, e[i]});
            acc(1'b0, 1'b0, `SMP_SER_MSR, 8'h00, q);
            chk("modem status", q, e);
            chk("irq after status read", {7'h00, sirq}, 8'h00);
         end
      end
      modem_irq_en = 1'b0;
      $display("test modem status done");
   endtask

   task automatic t_printer();
      logic [7:0] q;
      wr(1'b1, `SMP_PRN_CTRL, 8'h10);
      chk("printer irq oe", {6'h00, pirq_oe, pirq}, 8'h02);
      ack_lvl = 1'b0;
      idle(3);
      ack_lvl = 1'b1;
      fault = 1'b1;
      no_paper = 1'b1;
      idle(5);
      chk("printer irq on ack rise", {7'h00, pirq}, 8'h01);
      acc(1'b1, 1'b0, `SMP_PRN_STAT, 8'h00, q);
      chk("printer status", q & 8'h6C, 8'h64);
      chk("printer irq cleared", {7'h00, pirq}, 8'h00);
      wr(1'b1, `SMP_PRN_CTRL, 8'h04);
      chk("init pulled low", {6'h00, pirq_oe, init_wire}, 8'h00);
      acc(1'b1, 1'b0, `SMP_PRN_CTRL, 8'h00, q);
      chk("printer control read back", q, 8'h04);
      wr(1'b1, `SMP_PRN_CTRL, 8'h00);
      chk("init released", {7'h00, init_wire}, 8'h01);
      wr(1'b1, `SMP_PRN_DATA, 8'hA5);
      pout_en_n = 1'b0;
      idle(5);
      chk("parallel lines driven", pd_wire, 8'hA5);
      chk("parallel oe", {7'h00, pd_oe}, 8'h01);
      pout_en_n = 1'b1;
      idle(5);
      chk("parallel lines floated", {7'h00, pd_oe}, 8'h00);
      acc(1'b1, 1'b0, `SMP_PRN_DATA, 8'h00, q);
      chk("write data read back", q, 8'hA5);
      acc(1'b0, 1'b0, 3'h3, 8'h00, q);
      chk("unmapped read", q, 8'h00);
      $display("test printer port done");
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      idle(6);
      chk("outputs in reset", outs(), 8'hC0);
      arst_n = 1'b1;
      idle(6);
      t_modem_ctrl();
      t_irq_causes();
      t_modem_status();
      t_printer();
      results();
   end
endmodule
`default_nettype wire
